//--- common/xcd_params.svh
// Constants for the crystal clock divider and frequency word block.
// Assumes inclusion from the package and the design files by bare name.
`ifndef XCD_PARAMS_SVH
`define XCD_PARAMS_SVH

// Core clock rate in MHz
`define XCD_CORE_CLK_MHZ      100

// Divide ratios
`define XCD_MCU_DIV           3
`define XCD_BASE_DIV          16

// Register bus widths
`define XCD_ADDR_W            3
`define XCD_DATA_W            8

// Register offsets
`define XCD_OFS_CTRL          3'h0
`define XCD_OFS_MULT          3'h1
`define XCD_OFS_PART_A        3'h2
`define XCD_OFS_PART_B        3'h3
`define XCD_OFS_STATUS        3'h4
`define XCD_OFS_WORD_LO       3'h5
`define XCD_OFS_WORD_HI       3'h6

// Reset values
`define XCD_RST_CTRL          8'h01
`define XCD_RST_MULT          8'h01
`define XCD_RST_PART_A        8'h00
`define XCD_RST_PART_B        8'h00

// Control register fields
`define XCD_CTRL_CLK_EN       0
`define XCD_CTRL_BAND_SEL     1
`define XCD_CTRL_RANGE_LO     2
`define XCD_CTRL_MODE_LO      4

// Status register fields
`define XCD_STAT_OSC_OK       0
`define XCD_STAT_SUPPLY_OK    1
`define XCD_STAT_CLK_ON       2
`define XCD_STAT_BAND_HIGH    3
`define XCD_STAT_WORD_OK      4

// Frequency word
`define XCD_WORD_W            13
`define XCD_PART_B_W          5
`define XCD_WORD_MIN          13'd3803
`define XCD_WORD_MAX          13'd4053
// Twice the integer part N and twice the fixed offset 20.5
`define XCD_N_X2_LOW_BAND     8'd65
`define XCD_N_X2_HIGH_BAND    8'd129
`define XCD_OFFSET_X2         15'd41

`endif

//--- common/xcd_pkg.sv
// Types for the crystal clock divider and frequency word block.
// Assumes the constants header is on the include path.
`include "xcd_params.svh"

package xcd_pkg;

  typedef enum logic [1:0] {
    XCD_MODE_IDLE,
    XCD_MODE_SLEEP,
    XCD_MODE_RX,
    XCD_MODE_TX
  } xcd_mode_type;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] bit_rate_range;
    logic       band_select_bit;
    logic       clk_out_en;
  } xcd_ctrl_type;

  typedef struct packed {
    logic [7:0]                 n_x2;
    logic [14:0]                frac_x2;
    logic [`XCD_WORD_W-1:0]     synth_frequency_word;
  } xcd_synth_type;

  typedef struct packed {
    logic                       wr;
    logic                       rd;
    logic [`XCD_ADDR_W-1:0]     addr;
    logic [`XCD_DATA_W-1:0]     wdata;
  } xcd_bus_req_type;

endpackage

//--- design/xcd_tick_div.sv
// Free running modulo counter with a one-cycle tick on wrap.
// Assumes a synchronous active high reset on the same clock.
`timescale 1ns/1ps
`default_nettype none

module xcd_tick_div #(
  parameter int WIDTH   = 4,
  parameter int MODULUS = 16
) (
  // Clock and reset
  input  wire logic             core_clk_in,
  input  wire logic             sys_rst_in,
  // Count state
  output logic [WIDTH-1:0]      count_out,
  output logic                  tick_out
);

  localparam logic [WIDTH-1:0] LAST = WIDTH'(MODULUS - 1);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count_out <= '0;
    end else if (count_out == LAST) begin
      count_out <= '0;
    end else begin
      count_out <= count_out + WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= (count_out == LAST - WIDTH'(1));
    end
  end

endmodule

`default_nettype wire

//--- design/xcd_clock_gen.sv
// Clock generation from the crystal oscillator reference: divided
// microcontroller clock, digital base tick, bit-check tick, and the
// synthesizer frequency word with band setup.
// Assumes core_clk_in is the oscillator output; analog status pins are
// asynchronous; register port master follows the plain strobe protocol.
//
// Notes on behaviour
// - Microcontroller clock is oscillator divided by three.
// - Microcontroller clock high half, low half.
// - Enable unsynchronised; first period may be short.
// - Amplitude ok flag releases host reset high.
// - Clock out needs amplitude ok, enable, supplies.
// - Base tick is oscillator divided by sixteen.
// - Base tick times polling check and transmit rate.
// - Bit clock equals base times multiplier times range.
// - Frequency word is sum of two parts.
// - RF factor uses band half-integer N plus word.
// - Idle and sleep reduce oscillator load capacitance.
// - Low supply output holds clock low, interface off.
//
// Added by the designer: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "xcd_params.svh"

module xcd_clock_gen (
  // Clock and reset
  input  wire logic                     core_clk_in,
  input  wire logic                     sys_rst_in,
  // Register port
  input  wire xcd_pkg::xcd_bus_req_type bus_req_in,
  output logic [`XCD_DATA_W-1:0]        rdata_out,
  // Analog status pins
  input  wire logic                     amp_detect_in,
  input  wire logic                     supply_output_ok_in,
  input  wire logic                     digital_supply_ok_in,
  input  wire logic                     band_select_pin_in,
  // Microcontroller side
  output logic                          mcu_clk_out,
  output logic                          host_rst_n_out,
  output logic                          mcu_if_enable_out,
  // Timing ticks
  output logic                          base_tick_out,
  output logic                          bit_check_tick_out,
  // Synthesizer and oscillator control
  output xcd_pkg::xcd_synth_type        synth_out,
  output logic                          load_cap_reduce_out
);

  import xcd_pkg::*;

  localparam int SYNC_W = 4;

  // Input synchronisers
  logic [SYNC_W-1:0] async_pins;
  logic [SYNC_W-1:0] sync_meta_r;
  logic [SYNC_W-1:0] sync_r;

  assign async_pins = {band_select_pin_in, digital_supply_ok_in,
                       supply_output_ok_in, amp_detect_in};

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      sync_meta_r <= '0;
      sync_r      <= '0;
    end else begin
      sync_meta_r <= async_pins;
      sync_r      <= sync_meta_r;
    end
  end

  logic amp_ok_s;
  logic supply_ok_s;
  logic dsupply_ok_s;
  logic band_pin_s;

  assign amp_ok_s     = sync_r[0];
  assign supply_ok_s  = sync_r[1];
  assign dsupply_ok_s = sync_r[2];
  assign band_pin_s   = sync_r[3];

  // Supply and amplitude state
  logic osc_amplitude_ok_r;
  logic supplies_ok;

  assign supplies_ok = supply_ok_s & dsupply_ok_s;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      osc_amplitude_ok_r <= 1'b0;
    end else if (!dsupply_ok_s) begin
      osc_amplitude_ok_r <= 1'b0;
    end else begin
      osc_amplitude_ok_r <= amp_ok_s;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      host_rst_n_out <= 1'b0;
    end else begin
      host_rst_n_out <= osc_amplitude_ok_r & supply_ok_s;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mcu_if_enable_out <= 1'b0;
    end else begin
      mcu_if_enable_out <= supply_ok_s;
    end
  end

  // Registers
  xcd_ctrl_type            ctrl_r;
  logic [7:0]              mult_r;
  logic [7:0]              part_a_r;
  logic [`XCD_PART_B_W-1:0] part_b_r;
  logic                    wr_ok;
  logic                    rd_ok;

  assign wr_ok = bus_req_in.wr & mcu_if_enable_out;
  assign rd_ok = bus_req_in.rd & mcu_if_enable_out;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      ctrl_r <= xcd_ctrl_type'(6'(`XCD_RST_CTRL));
    end else if (wr_ok && bus_req_in.addr == `XCD_OFS_CTRL) begin
      ctrl_r <= xcd_ctrl_type'(bus_req_in.wdata[5:0]);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      mult_r <= `XCD_RST_MULT;
    end else if (wr_ok && bus_req_in.addr == `XCD_OFS_MULT) begin
      mult_r <= bus_req_in.wdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      part_a_r <= `XCD_RST_PART_A;
    end else if (wr_ok && bus_req_in.addr == `XCD_OFS_PART_A) begin
      part_a_r <= bus_req_in.wdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      part_b_r <= `XCD_PART_B_W'(`XCD_RST_PART_B);
    end else if (wr_ok && bus_req_in.addr == `XCD_OFS_PART_B) begin
      part_b_r <= bus_req_in.wdata[`XCD_PART_B_W-1:0];
    end
  end

  // Divide by three for the microcontroller clock
  logic [1:0] div3_count;
  logic       clk_pos_r;
  logic       clk_neg_r;
  logic       clk_gate_r;

  xcd_tick_div #(
    .WIDTH   (2),
    .MODULUS (`XCD_MCU_DIV)
  ) u_div3 (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .count_out   (div3_count),
    .tick_out    ()
  );

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_pos_r <= 1'b0;
    end else begin
      clk_pos_r <= (div3_count == 2'h2);
    end
  end

  // Half-cycle delayed copy stretches high time to 1.5 cycles
  always_ff @(negedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_neg_r <= 1'b0;
    end else begin
      clk_neg_r <= clk_pos_r;
    end
  end

  // Gate is not aligned to the divider phase
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      clk_gate_r <= 1'b0;
    end else begin
      clk_gate_r <= osc_amplitude_ok_r & ctrl_r.clk_out_en & supplies_ok;
    end
  end

  assign mcu_clk_out = clk_gate_r & (clk_pos_r | clk_neg_r);

  // Digital base tick
  logic base_tick;

  xcd_tick_div #(
    .WIDTH   (4),
    .MODULUS (`XCD_BASE_DIV)
  ) u_div16 (
    .core_clk_in (core_clk_in),
    .sys_rst_in  (sys_rst_in),
    .count_out   (),
    .tick_out    (base_tick)
  );

  assign base_tick_out = base_tick;

  // Bit-check and transmit bit tick
  logic [10:0] bit_count_r;
  logic [10:0] bit_last;
  logic [7:0]  mult_eff;

  // A zero multiplier acts as one
  assign mult_eff = (mult_r == 8'h00) ? 8'h01 : mult_r;
  assign bit_last = ({3'b000, mult_eff} << (2'd3 - ctrl_r.bit_rate_range)) - 11'd1;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bit_count_r <= '0;
    end else if (base_tick) begin
      if (bit_count_r >= bit_last) begin
        bit_count_r <= '0;
      end else begin
        bit_count_r <= bit_count_r + 11'd1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      bit_check_tick_out <= 1'b0;
    end else begin
      bit_check_tick_out <= base_tick && (bit_count_r >= bit_last);
    end
  end

  // Frequency word and band setup
  logic [`XCD_WORD_W-1:0] word_part_a;
  logic [`XCD_WORD_W-1:0] word_part_b;
  logic [`XCD_WORD_W-1:0] word_sum;
  logic                   band_high;
  logic                   word_in_range;

  assign word_part_a = {5'b00000, part_a_r};
  assign word_part_b = {part_b_r, 8'h00};
  assign word_sum    = word_part_a + word_part_b;

  // Grounded band pin with band bit clear selects the upper band
  assign band_high = ~band_pin_s & ~ctrl_r.band_select_bit;

  // Aid for the controller; range itself is its duty
  assign word_in_range = (word_sum >= `XCD_WORD_MIN) &&
                         (word_sum <= `XCD_WORD_MAX);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      synth_out <= '0;
    end else begin
      synth_out.synth_frequency_word <= word_sum;
      synth_out.n_x2    <= band_high ? `XCD_N_X2_HIGH_BAND
                                     : `XCD_N_X2_LOW_BAND;
      synth_out.frac_x2 <= {1'b0, word_sum, 1'b0} + `XCD_OFFSET_X2;
    end
  end

  // Oscillator load capacitor switching
  xcd_mode_type mode;

  assign mode = xcd_mode_type'(ctrl_r.mode);

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      load_cap_reduce_out <= 1'b1;
    end else begin
      unique case (mode)
        XCD_MODE_IDLE:  load_cap_reduce_out <= 1'b1;
        XCD_MODE_SLEEP: load_cap_reduce_out <= 1'b1;
        XCD_MODE_RX:    load_cap_reduce_out <= 1'b0;
        XCD_MODE_TX:    load_cap_reduce_out <= 1'b0;
      endcase
    end
  end

  // Read path
  logic [`XCD_DATA_W-1:0] status;
  logic [`XCD_DATA_W-1:0] rd_mux;

  always_comb begin
    status = '0;
    status[`XCD_STAT_OSC_OK]    = osc_amplitude_ok_r;
    status[`XCD_STAT_SUPPLY_OK] = supplies_ok;
    status[`XCD_STAT_CLK_ON]    = clk_gate_r;
    status[`XCD_STAT_BAND_HIGH] = band_high;
    status[`XCD_STAT_WORD_OK]   = word_in_range;
  end

  always_comb begin
    rd_mux = '0;
    unique case (bus_req_in.addr)
      `XCD_OFS_CTRL:    rd_mux = {2'b00, ctrl_r};
      `XCD_OFS_MULT:    rd_mux = mult_r;
      `XCD_OFS_PART_A:  rd_mux = part_a_r;
      `XCD_OFS_PART_B:  rd_mux = {3'b000, part_b_r};
      `XCD_OFS_STATUS:  rd_mux = status;
      `XCD_OFS_WORD_LO: rd_mux = word_sum[7:0];
      `XCD_OFS_WORD_HI: rd_mux = {3'b000, word_sum[12:8]};
      default:          rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= '0;
    end else if (rd_ok) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= '0;
    end
  end

endmodule

`default_nettype wire

//--- dv/xcd_clock_gen_properties.sv
// Port checker for the clock generation block.
// Assumes it is bound to xcd_clock_gen and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module xcd_clock_gen_properties (
  // Clock and reset
  input wire logic                     core_clk_in,
  input wire logic                     sys_rst_in,
  // Watched ports
  input wire xcd_pkg::xcd_bus_req_type bus_req_in,
  input wire logic [7:0]               rdata_out,
  input wire logic                     amp_detect_in,
  input wire logic                     supply_output_ok_in,
  input wire logic                     band_select_pin_in,
  input wire logic                     mcu_clk_out,
  input wire logic                     host_rst_n_out,
  input wire logic                     mcu_if_enable_out,
  input wire logic                     base_tick_out,
  input wire logic                     bit_check_tick_out,
  input wire xcd_pkg::xcd_synth_type   synth_out
);
  import xcd_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  base_tick_period_a: assert property (base_tick_out |-> ##16 base_tick_out)
    else $error("base tick period wrong");
  base_tick_gap_a: assert property (base_tick_out |=> !base_tick_out [*8])
    else $error("base tick too soon");
  bit_on_base_a: assert property (bit_check_tick_out |-> $past(base_tick_out))
    else $error("bit tick off base tick");
  read_data_idle_a: assert property (!$past(bus_req_in.rd) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  frac_sum_a: assert property ((!$past(sys_rst_in) &&
    $stable(synth_out.synth_frequency_word)) [*2] |->
    synth_out.frac_x2 == {1'b0, synth_out.synth_frequency_word, 1'b0} + 15'h0029)
    else $error("fraction wrong");
  band_legal_a: assert property (!$past(sys_rst_in) |-> synth_out.n_x2 inside {8'h41, 8'h81})
    else $error("integer part illegal");
  band_pin_low_a: assert property (band_select_pin_in [*5] |-> synth_out.n_x2 == 8'h41)
    else $error("lower band not used");
  supply_low_a: assert property (!supply_output_ok_in [*5] |->
    !mcu_clk_out && !host_rst_n_out && !mcu_if_enable_out)
    else $error("low supply not obeyed");
  amp_low_a: assert property (!amp_detect_in [*5] |-> !host_rst_n_out && !mcu_clk_out)
    else $error("clock or reset without amplitude");
  cover property ($rose(mcu_clk_out));
  cover property (bit_check_tick_out);
  cover property (bus_req_in.rd ##1 rdata_out != 8'h00);
endmodule
bind xcd_clock_gen xcd_clock_gen_properties chk (.core_clk_in, .sys_rst_in, .bus_req_in,
  .rdata_out, .amp_detect_in, .supply_output_ok_in, .band_select_pin_in, .mcu_clk_out,
  .host_rst_n_out, .mcu_if_enable_out, .base_tick_out, .bit_check_tick_out, .synth_out);
`default_nettype wire

//--- dv/xcd_mcu_model.sv
// Model of a controller clocked from the divided clock output.
// Assumes the clock is held low while stopped.
`timescale 1ns/1ps
`default_nettype none
module xcd_mcu_model (
  // Clock and reset from the device
  input  wire logic   mcu_clk_in,
  input  wire logic   host_rst_n_in,
  // Measurements
  output var realtime hi_ns_out,
  output var realtime lo_ns_out,
  output var int      edges_out
);
  realtime t_up = 0.0;
  realtime t_dn = 0.0;
  initial edges_out = 0;
  // Only last widths kept, so a short first period is tolerated
  always @(posedge mcu_clk_in) begin
    lo_ns_out = $realtime - t_dn;
    t_up = $realtime;
    edges_out = edges_out + 1;
  end
  always @(negedge mcu_clk_in) begin
    hi_ns_out = $realtime - t_up;
    t_dn = $realtime;
  end
endmodule
`default_nettype wire

//--- dv/xcd_clock_gen_tb.sv
// Testbench for the clock generation block.
// Assumes the package, checker and controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module xcd_clock_gen_tb;
  import xcd_pkg::*;
  typedef struct {logic [2:0] a; logic [7:0] d; logic [7:0] e;} xcd_row_type;
  logic            core_clk_in = 1'b0;
  logic            sys_rst_in = 1'b1;
  xcd_bus_req_type bus_req_in = '0;
  logic            amp_detect_in = 1'b0;
  logic            supply_output_ok_in = 1'b1;
  logic            digital_supply_ok_in = 1'b1;
  logic            band_select_pin_in = 1'b1;
  logic [7:0]      rdata_out;
  logic            mcu_clk_out, host_rst_n_out, mcu_if_enable_out;
  logic            base_tick_out, bit_check_tick_out, load_cap_reduce_out;
  xcd_synth_type   synth_out;
  realtime         hi_ns, lo_ns;
  int              edges, n, n_errors = 0, checks = 0;
  xcd_row_type     rows [7];
  always #5 core_clk_in = ~core_clk_in;
  xcd_clock_gen dut (.core_clk_in, .sys_rst_in, .bus_req_in, .rdata_out, .amp_detect_in,
    .supply_output_ok_in, .digital_supply_ok_in, .band_select_pin_in, .mcu_clk_out,
    .host_rst_n_out, .mcu_if_enable_out, .base_tick_out, .bit_check_tick_out, .synth_out,
    .load_cap_reduce_out);
  xcd_mcu_model mcu (.mcu_clk_in(mcu_clk_out), .host_rst_n_in(host_rst_n_out),
    .hi_ns_out(hi_ns), .lo_ns_out(lo_ns), .edges_out(edges));
  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge core_clk_in);
    bus_req_in <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge core_clk_in);
    bus_req_in <= '0;
  endtask
  task automatic rchk(string nm, logic [2:0] a, logic [7:0] e);
    @(posedge core_clk_in);
    bus_req_in <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk_in);
    bus_req_in <= '0;
    #1 chk(nm, {8'h00, rdata_out}, {8'h00, e});
  endtask
  task automatic gap(logic sel, output int c);
    int k;
    k = 0;
    c = 0;
    do begin
      @(negedge core_clk_in);
      k++;
    end while ((sel ? bit_check_tick_out : base_tick_out) !== 1'b1 && k < 3000);
    do begin
      @(negedge core_clk_in);
      c++;
    end while ((sel ? bit_check_tick_out : base_tick_out) !== 1'b1 && c < 3000);
  endtask
  task automatic wait_n(int c);
    repeat (c) @(negedge core_clk_in);
  endtask
  initial begin
    #300000;
    n_errors++;
    end_sim();
  end
  initial begin
    // Word 3803 kept in the single-channel range
    rows = '{'{3'h0, 8'h0D, 8'h0D}, '{3'h1, 8'h02, 8'h02}, '{3'h2, 8'hDB, 8'hDB},
      '{3'h3, 8'h0E, 8'h0E}, '{3'h7, 8'h55, 8'h00}, '{3'h5, 8'hFF, 8'hDB}, '{3'h6, 8'h00, 8'h0E}};
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    wait_n(1);
    chk("host reset", host_rst_n_out, 16'h0000);
    chk("load cap", load_cap_reduce_out, 16'h0001);
    wait_n(4);
    rchk("ctrl reset", 3'h0, 8'h01);
    rchk("mult reset", 3'h1, 8'h01);
    gap(1'b0, n);
    chk("base period", n[15:0], 16'h0010);
    gap(1'b1, n);
    chk("bit period", n[15:0], 16'h0080);
    $display("reset test done");
    @(posedge core_clk_in);
    amp_detect_in <= 1'b1;
    wait_n(8);
    chk("host released", host_rst_n_out, 16'h0001);
    wait_n(10);
    chk("clk high", hi_ns > 14.9 && hi_ns < 15.1, 16'h0001);
    chk("clk low", lo_ns > 14.9 && lo_ns < 15.1, 16'h0001);
    rchk("status", 3'h4, 8'h07);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rchk("reg", rows[i].a, rows[i].e);
    end
    wait_n(2);
    chk("word", synth_out.synth_frequency_word, 16'h0EDB);
    chk("frac", synth_out.frac_x2, 16'h1DDF);
    rchk("status word", 3'h4, 8'h17);
    $display("register test done");
    for (int r = 0; r < 4; r++) begin
      wr(3'h0, {4'h0, r[1:0], 2'b01});
      gap(1'b1, n);
      gap(1'b1, n);
      chk("range period", n[15:0], 16'h0020 << (3 - r));
    end
    for (int m = 0; m < 4; m++) begin
      wr(3'h0, {2'b00, m[1:0], 4'h1});
      wait_n(4);
      chk("load cap mode", load_cap_reduce_out, {15'h0000, m < 2});
    end
    @(posedge core_clk_in);
    band_select_pin_in <= 1'b0;
    wait_n(6);
    chk("upper band", synth_out.n_x2, 16'h0081);
    wr(3'h0, 8'h03);
    wait_n(4);
    chk("band bit", synth_out.n_x2, 16'h0041);
    band_select_pin_in <= 1'b1;
    $display("timing test done");
    wr(3'h0, 8'h00);
    wait_n(4);
    n = edges;
    wait_n(10);
    chk("clk stopped", edges == n, 16'h0001);
    @(posedge core_clk_in);
    supply_output_ok_in <= 1'b0;
    wait_n(6);
    chk("if off", mcu_if_enable_out, 16'h0000);
    wr(3'h1, 8'h07);
    rchk("blocked read", 3'h1, 8'h00);
    supply_output_ok_in <= 1'b1;
    wait_n(6);
    rchk("mult kept", 3'h1, 8'h02);
    @(posedge core_clk_in);
    digital_supply_ok_in <= 1'b0;
    wait_n(6);
    chk("dsupply reset", host_rst_n_out, 16'h0000);
    rchk("dsupply status", 3'h4, 8'h10);
    digital_supply_ok_in <= 1'b1;
    wait_n(6);
    rchk("dsupply back", 3'h4, 8'h13);
    $display("supply test done");
    end_sim();
  end
endmodule
`default_nettype wire
